// ### testbench/test_alu_branch_exec.sv
`timescale 1ns/10ps
module test_alu_branch_exec;
  import alu_exec_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk_sys;
  logic arst_n;
  logic [ADDR_W-1:0] avAddress;
  logic avRead;
  logic avWrite;
  logic [31:0] avWritedata;
  logic [31:0] avReaddata;
  logic avWaitrequest;
  logic busy;
  int err_count;
  int tests_run;
  int waits;
  logic busyAfter;
  logic [31:0] scratch;

  alu_branch_exec #(.STACK_DEPTH(8)) u_alu_branch_exec (
    .clk_sys(clk_sys), .arst_n(arst_n), .avAddress(avAddress), .avRead(avRead), .avWrite(avWrite),
    .avWritedata(avWritedata), .avReaddata(avReaddata), .avWaitrequest(avWaitrequest), .busy(busy)
  );

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // bus and compare helpers
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] expVal, input logic [31:0] gotVal);
    tests_run++;
    if (gotVal !== expVal) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", name, expVal, gotVal);
    end
  endtask : chk

  // waitrequest and read data are taken at the rising edge, before the design updates them;
  // one idle edge follows each access so no strobe is lowered and raised in one time step
  task automatic busCycle(input logic rd, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                          output logic [31:0] q);
    avAddress <= a;
    avRead <= rd;
    avWrite <= ~rd;
    avWritedata <= d;
    waits = 0;
    @(posedge clk_sys);
    while (avWaitrequest !== 1'b0) begin
      waits++;
      @(posedge clk_sys);
    end
    q = avReaddata;
    avRead <= 1'b0;
    avWrite <= 1'b0;
    @(posedge clk_sys);
    busyAfter = busy;
  endtask : busCycle

  task automatic avWr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    busCycle(1'b0, a, d, scratch);
  endtask : avWr

  task automatic rdChk(input logic [ADDR_W-1:0] a, input string name, input logic [31:0] expVal);
    logic [31:0] q;
    busCycle(1'b1, a, 32'h0, q);
    chk("read wait cycles", 32'h1, 32'(waits));
    chk(name, expVal, q);
  endtask : rdChk

  task automatic exec(input op_type op, input logic twoWord);
    avWr(REG_CMD, 32'(op) | (32'(twoWord) << CMD_LONG_BIT));
  endtask : exec

  task automatic statChk(input logic [2:0] expCyc, input logic [2:0] expSp, input logic expSkip);
    logic [31:0] q;
    logic opBusy;
    // busy seen right after the command, before the status read overwrites it
    opBusy = busyAfter;
    busCycle(1'b1, REG_STATUS, 32'h0, q);
    chk("cycle count", 32'(expCyc), 32'(q[STAT_CYC_LSB +: CYC_W]));
    chk("stack depth", 32'(expSp), 32'(q[STAT_SP_LSB +: 3]));
    chk("skip flag", 32'(expSkip), 32'(q[STAT_SKIP_BIT]));
    chk("busy after op", 32'(expCyc > 3'h1), 32'(opBusy));
  endtask : statChk

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic resetValues;
    rdChk(REG_PC, "pc after reset", 32'(PC_RESET));
    rdChk(REG_SREG, "flags after reset", 32'(SREG_RESET));
    rdChk(REG_STATUS, "status after reset", 32'h0);
    avWr(4'hf, 32'h1234);
    rdChk(4'hf, "unmapped read", 32'h0);
    avWr(REG_PROD, 32'hffff);
    rdChk(REG_PROD, "product write ignored", 32'h0);
  endtask : resetValues

  task automatic byteOp(input op_type op, input logic [7:0] d, input logic [7:0] s, input logic [7:0] k,
                        input logic [7:0] sIn, input logic [7:0] expD, input logic [7:0] expS);
    avWr(REG_DST, {24'h0, d});
    avWr(REG_SRC, {24'h0, s});
    avWr(REG_IMM, {24'h0, k});
    avWr(REG_SREG, {24'h0, sIn});
    exec(op, 1'b0);
    statChk(3'h1, 3'h0, 1'b0);
    rdChk(REG_DST, "destination byte", {24'h0, expD});
    rdChk(REG_SREG, "flags after byte op", {24'h0, expS});
  endtask : byteOp

  task automatic wordOp(input op_type op, input logic [15:0] w, input logic [7:0] k, input logic [7:0] sIn,
                        input logic [15:0] expW, input logic [7:0] expS);
    avWr(REG_WORD, {16'h0, w});
    avWr(REG_IMM, {24'h0, k});
    avWr(REG_SREG, {24'h0, sIn});
    exec(op, 1'b0);
    statChk(3'h2, 3'h0, 1'b0);
    rdChk(REG_WORD, "register pair", {16'h0, expW});
    rdChk(REG_SREG, "flags after word op", {24'h0, expS});
  endtask : wordOp

  // negative, overflow and half carry start set so a stray update shows
  task automatic mulOp(input op_type op, input logic [7:0] a, input logic [7:0] b,
                       input logic [15:0] expP, input logic [7:0] expS);
    avWr(REG_DST, {24'h0, a});
    avWr(REG_SRC, {24'h0, b});
    avWr(REG_SREG, 32'h2c);
    exec(op, 1'b0);
    statChk(3'h2, 3'h0, 1'b0);
    rdChk(REG_PROD, "product pair", {16'h0, expP});
    rdChk(REG_SREG, "flags after product", {24'h0, expS});
  endtask : mulOp

  task automatic flowStep(input op_type op, input logic [15:0] v, input logic [15:0] expPc,
                          input logic [2:0] expSp, input logic [2:0] expCyc, input logic [7:0] expS);
    avWr(REG_ZPTR, {16'h0, v});
    avWr(REG_IMM, {16'h0, v});
    exec(op, 1'b0);
    statChk(expCyc, expSp, 1'b0);
    rdChk(REG_PC, "program counter", {16'h0, expPc});
    rdChk(REG_SREG, "flags after flow op", {24'h0, expS});
  endtask : flowStep

  task automatic skipOp(input logic [7:0] d, input logic [7:0] s, input logic twoWord,
                        input logic [15:0] expPc, input logic [2:0] expCyc, input logic expSkip);
    avWr(REG_PC, 32'h0010);
    avWr(REG_SREG, 32'h2f);
    avWr(REG_DST, {24'h0, d});
    avWr(REG_SRC, {24'h0, s});
    exec(OP_EQUAL_SKIP, twoWord);
    statChk(expCyc, 3'h0, expSkip);
    rdChk(REG_PC, "pc after compare", {16'h0, expPc});
    rdChk(REG_SREG, "flags after compare", 32'h2f);
  endtask : skipOp

  // a write issued right behind a four-cycle op must be held off until busy drops
  task automatic stallCheck;
    avWr(REG_IMM, 32'h0300);
    exec(OP_ABS_ENTRY, 1'b0);
    chk("busy behind long op", 32'h1, 32'(busyAfter));
    avWr(REG_IMM, 32'h0055);
    chk("write wait cycles", 32'h2, 32'(waits));
    rdChk(REG_IMM, "constant after stall", 32'h0055);
    exec(OP_SUB_EXIT, 1'b0);
  endtask : stallCheck

  task automatic end_sim;
    $display("checks run %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    avAddress = '0;
    avRead = 1'b0;
    avWrite = 1'b0;
    avWritedata = 32'h0;
    err_count = 0;
    tests_run = 0;
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    resetValues();
    byteOp(OP_ADD_CARRY, 8'h8f, 8'h71, 8'h00, 8'h01, 8'h01, 8'h21);
    byteOp(OP_ADD, 8'h8f, 8'h71, 8'h00, 8'h01, 8'h00, 8'h23);
    byteOp(OP_SUB, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h02);
    byteOp(OP_AND, 8'hf0, 8'h3c, 8'h0f, 8'h29, 8'h30, 8'h21);
    byteOp(OP_OR, 8'h80, 8'h01, 8'h00, 8'h29, 8'h81, 8'h25);
    byteOp(OP_DIFF_IMM, 8'h10, 8'h00, 8'h20, 8'h00, 8'hf0, 8'h05);
    byteOp(OP_DIFF_BORROW, 8'h00, 8'h00, 8'h00, 8'h01, 8'hff, 8'h25);
    byteOp(OP_DIFF_IMM_BORROW, 8'h80, 8'h00, 8'h00, 8'h01, 8'h7f, 8'h28);
    byteOp(OP_AND_IMM, 8'hf0, 8'h00, 8'h0f, 8'h29, 8'h00, 8'h23);
    byteOp(OP_OR_IMM, 8'h80, 8'h00, 8'h01, 8'h29, 8'h81, 8'h25);
    byteOp(OP_ONES_COMP, 8'h55, 8'h00, 8'h00, 8'h20, 8'haa, 8'h25);
    byteOp(OP_TWOS_COMP, 8'h01, 8'h00, 8'h00, 8'h00, 8'hff, 8'h25);
    byteOp(OP_SET_MASK, 8'h00, 8'h00, 8'h00, 8'h0d, 8'h00, 8'h03);
    byteOp(OP_CLEAR_MASK, 8'hff, 8'h00, 8'h0f, 8'h29, 8'hf0, 8'h25);
    byteOp(OP_ZERO_MINUS_CHECK, 8'h00, 8'h00, 8'h00, 8'h2d, 8'h00, 8'h23);
    wordOp(OP_WORD_INC, 16'hffff, 8'h01, 8'h20, 16'h0000, 8'h23);
    wordOp(OP_WORD_INC, 16'h7fc1, 8'h3f, 8'h00, 16'h8000, 8'h0c);
    wordOp(OP_WORD_DEC, 16'h0000, 8'h01, 8'h00, 16'hffff, 8'h15);
    wordOp(OP_WORD_DEC, 16'h8000, 8'h01, 8'h00, 16'h7fff, 8'h18);
    mulOp(OP_PROD_U, 8'hff, 8'hff, 16'hfe01, 8'h2d);
    mulOp(OP_PROD_U, 8'h00, 8'h12, 16'h0000, 8'h2e);
    mulOp(OP_PROD_S, 8'hff, 8'h02, 16'hfffe, 8'h2d);
    mulOp(OP_PROD_SU, 8'h80, 8'h02, 16'hff00, 8'h2d);
    mulOp(OP_FRAC_U, 8'h80, 8'h80, 16'h8000, 8'h2c);
    mulOp(OP_FRAC_S, 8'h80, 8'h80, 16'h8000, 8'h2c);
    mulOp(OP_FRAC_SU, 8'hc0, 8'h40, 16'he000, 8'h2d);
    avWr(REG_PC, 32'h1000);
    avWr(REG_SREG, 32'h00);
    flowStep(OP_IND_GOTO, 16'h1234, 16'h1234, 3'h0, 3'h2, 8'h00);
    flowStep(OP_IND_ENTRY, 16'h0200, 16'h0200, 3'h1, 3'h3, 8'h00);
    flowStep(OP_SUB_EXIT, 16'h0000, 16'h1235, 3'h0, 3'h4, 8'h00);
    flowStep(OP_REL_GOTO, 16'h0010, 16'h1246, 3'h0, 3'h2, 8'h00);
    flowStep(OP_REL_ENTRY, 16'hfffe, 16'h1245, 3'h1, 3'h3, 8'h00);
    flowStep(OP_ABS_GOTO, 16'h4000, 16'h4000, 3'h1, 3'h3, 8'h00);
    flowStep(OP_ABS_ENTRY, 16'h0300, 16'h0300, 3'h2, 3'h4, 8'h00);
    flowStep(OP_HANDLER_EXIT, 16'h0000, 16'h4002, 3'h1, 3'h4, 8'h80);
    flowStep(OP_SUB_EXIT, 16'h0000, 16'h1247, 3'h0, 3'h4, 8'h80);
    skipOp(8'h33, 8'h33, 1'b0, 16'h0012, 3'h2, 1'b1);
    skipOp(8'h33, 8'h33, 1'b1, 16'h0013, 3'h3, 1'b1);
    skipOp(8'h33, 8'h34, 1'b0, 16'h0011, 3'h1, 1'b0);
    stallCheck();
    end_sim();
  end

  // the whole sequence needs well under a thousand cycles; a hang is cut well after that
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    $display("unexpected watchdog expiry: expected completion, seen hang");
    end_sim();
  end
endmodule : test_alu_branch_exec

// ### verilog/add_sub8.sv
`timescale 1ns/10ps
module add_sub8 (
  // operands
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic sub,
  input wire logic cin,
  // result and flags
  output logic [7:0] res,
  output logic carry,
  output logic halfCarry,
  output logic overflow
);
  logic [7:0] bx;
  logic ci;
  logic [4:0] lo;
  logic [8:0] full;

  // subtract as a + ~b + ~borrow, so one adder serves both directions
  assign bx = sub ? ~b : b;
  assign ci = sub ? ~cin : cin;
  assign lo = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, ci};
  assign full = {1'b0, a} + {1'b0, bx} + {8'h00, ci};
  assign res = full[7:0];
  assign carry = full[8] ^ sub;
  assign halfCarry = lo[4] ^ sub;
  assign overflow = (a[7] == bx[7]) && (res[7] != a[7]);
endmodule : add_sub8

// ### verilog/alu_branch_exec.sv
// The implementer's own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/10ps
// ------------------------------------------------------------------
// ------------------------------------------------------------------
module alu_branch_exec #(
  parameter int STACK_DEPTH = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // avalon-mm slave
  input wire logic [alu_exec_pkg::ADDR_W-1:0] avAddress,
  input wire logic avRead,
  input wire logic avWrite,
  input wire logic [31:0] avWritedata,
  output logic [31:0] avReaddata,
  output logic avWaitrequest,
  // execution status
  output logic busy
);
  import alu_exec_pkg::*;

  localparam int SP_W = $clog2(STACK_DEPTH);

  typedef struct packed {
    state_type state;
    logic [CYC_W-1:0] cnt;
    logic [CYC_W-1:0] lastCyc;
    op_type op;
    logic [7:0] dst;
    logic [7:0] src;
    logic [15:0] imm;
    logic [15:0] word;
    logic [15:0] zptr;
    logic [15:0] pc;
    logic [15:0] prod;
    logic [7:0] sreg;
    logic skipped;
    logic [SP_W-1:0] sp;
    logic [STACK_DEPTH-1:0][15:0] stack;
    logic rdValid;
    logic [31:0] rdData;
  } vars_type;

  vars_type vars_r;
  vars_type vars_nxt;

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  logic take;
  logic cmdTake;
  op_type opIn;
  logic longNext;

  assign busy = vars_r.state == ST_RUN;
  // writes stall while a multi-cycle operation runs; reads answer one cycle late
  assign avWaitrequest = (avRead && !vars_r.rdValid) || (avWrite && busy);
  assign take = avWrite && !busy;
  assign cmdTake = take && (avAddress == REG_CMD);
  assign opIn = op_type'(avWritedata[CMD_OP_MSB:CMD_OP_LSB]);
  assign longNext = avWritedata[CMD_LONG_BIT];
  assign avReaddata = vars_r.rdData;

  // ----------------------------------------------------------------
  // datapath units
  // ----------------------------------------------------------------
  logic isImm;
  logic [7:0] bOp;
  logic [7:0] asA;
  logic [7:0] asB;
  logic [7:0] asRes;
  logic asSub;
  logic asCin;
  logic asC;
  logic asH;
  logic asV;
  logic [15:0] mulProd;
  logic mulC;
  logic [15:0] wordK;
  logic [15:0] wordRes;
  logic wordC;
  logic wordV;
  logic [7:0] logRes;
  logic [15:0] pcInc;

  assign isImm = opIn inside {OP_DIFF_IMM, OP_DIFF_IMM_BORROW, OP_AND_IMM, OP_OR_IMM,
                              OP_SET_MASK, OP_CLEAR_MASK};
  assign bOp = isImm ? vars_r.imm[7:0] : vars_r.src;
  assign asA = (opIn == OP_TWOS_COMP) ? BYTE_ZERO : vars_r.dst;
  assign asB = (opIn == OP_TWOS_COMP) ? vars_r.dst : ((opIn inside {OP_INCR, OP_DECR}) ? BYTE_ONE : bOp);
  assign asSub = opIn inside {OP_SUB, OP_DIFF_IMM, OP_DIFF_BORROW, OP_DIFF_IMM_BORROW, OP_TWOS_COMP,
                              OP_DECR, OP_COMPARE};
  assign asCin = (opIn inside {OP_ADD_CARRY, OP_DIFF_BORROW, OP_DIFF_IMM_BORROW}) && vars_r.sreg[FLAG_C];

  add_sub8 u_addSub (
    .a(asA),
    .b(asB),
    .sub(asSub),
    .cin(asCin),
    .res(asRes),
    .carry(asC),
    .halfCarry(asH),
    .overflow(asV)
  );

  mul_unit u_mul (
    .a(vars_r.dst),
    .b(vars_r.src),
    .signA(opIn inside {OP_PROD_S, OP_PROD_SU, OP_FRAC_S, OP_FRAC_SU}),
    .signB(opIn inside {OP_PROD_S, OP_FRAC_S}),
    .frac(opIn inside {OP_FRAC_U, OP_FRAC_S, OP_FRAC_SU}),
    .product(mulProd),
    .carry(mulC)
  );

  // word constant is only six bits wide; upper bits of the immediate are ignored
  assign wordK = {{(16 - WORD_K_W){1'b0}}, vars_r.imm[WORD_K_W-1:0]};
  assign wordRes = (opIn == OP_WORD_DEC) ? vars_r.word - wordK : vars_r.word + wordK;
  assign wordV = (opIn == OP_WORD_DEC) ? (vars_r.word[15] && !wordRes[15]) : (!vars_r.word[15] && wordRes[15]);
  assign wordC = (opIn == OP_WORD_DEC) ? (wordRes[15] && !vars_r.word[15]) : (vars_r.word[15] && !wordRes[15]);
  assign pcInc = vars_r.pc + PC_STEP_ONE;

  always_comb begin
    unique case (opIn)
      OP_AND, OP_AND_IMM: logRes = vars_r.dst & bOp;
      OP_OR, OP_OR_IMM, OP_SET_MASK: logRes = vars_r.dst | bOp;
      OP_CLEAR_MASK: logRes = vars_r.dst & (BYTE_ONES - bOp);
      OP_ZERO_MINUS_CHECK: logRes = vars_r.dst & vars_r.dst;
      OP_XOR: logRes = vars_r.dst ^ bOp;
      OP_CLEAR_REG: logRes = vars_r.dst ^ vars_r.dst;
      default: logRes = vars_r.dst;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [CYC_W-1:0] cyc;
    cyc = CYC_ONE;
    vars_nxt = vars_r;
    vars_nxt.rdValid = avRead && !vars_r.rdValid;
    if (avRead && !vars_r.rdValid) begin
      unique case (avAddress)
        REG_CMD: vars_nxt.rdData = {26'h0000000, vars_r.op};
        REG_DST: vars_nxt.rdData = {24'h000000, vars_r.dst};
        REG_SRC: vars_nxt.rdData = {24'h000000, vars_r.src};
        REG_IMM: vars_nxt.rdData = {16'h0000, vars_r.imm};
        REG_WORD: vars_nxt.rdData = {16'h0000, vars_r.word};
        REG_ZPTR: vars_nxt.rdData = {16'h0000, vars_r.zptr};
        REG_PC: vars_nxt.rdData = {16'h0000, vars_r.pc};
        REG_SREG: vars_nxt.rdData = {24'h000000, vars_r.sreg};
        REG_PROD: vars_nxt.rdData = {16'h0000, vars_r.prod};
        REG_STATUS: begin
          vars_nxt.rdData = 32'h00000000;
          vars_nxt.rdData[STAT_BUSY_BIT] = busy;
          vars_nxt.rdData[STAT_SKIP_BIT] = vars_r.skipped;
          vars_nxt.rdData[STAT_CYC_LSB +: CYC_W] = vars_r.lastCyc;
          vars_nxt.rdData[STAT_SP_LSB +: SP_W] = vars_r.sp;
        end
        default: vars_nxt.rdData = 32'h00000000;
      endcase
    end
    if (take) begin
      unique case (avAddress)
        REG_DST: vars_nxt.dst = avWritedata[7:0];
        REG_SRC: vars_nxt.src = avWritedata[7:0];
        REG_IMM: vars_nxt.imm = avWritedata[15:0];
        REG_WORD: vars_nxt.word = avWritedata[15:0];
        REG_ZPTR: vars_nxt.zptr = avWritedata[15:0];
        REG_PC: vars_nxt.pc = avWritedata[15:0];
        REG_SREG: vars_nxt.sreg = avWritedata[7:0];
        default: ;
      endcase
    end
    if (busy) begin
      vars_nxt.cnt = vars_r.cnt - CYC_ONE;
      if (vars_r.cnt == CYC_ONE) begin
        vars_nxt.state = ST_IDLE;
      end
    end
    if (cmdTake) begin
      vars_nxt.op = opIn;
      vars_nxt.pc = pcInc;
      vars_nxt.skipped = 1'b0;
      unique case (opIn)
        OP_ADD, OP_ADD_CARRY, OP_SUB, OP_DIFF_IMM, OP_DIFF_BORROW, OP_DIFF_IMM_BORROW, OP_TWOS_COMP,
        OP_COMPARE: begin
          if (opIn != OP_COMPARE) begin
            vars_nxt.dst = asRes;
          end
          vars_nxt.sreg[FLAG_Z] = asRes == BYTE_ZERO;
          vars_nxt.sreg[FLAG_N] = asRes[7];
          vars_nxt.sreg[FLAG_V] = asV;
          vars_nxt.sreg[FLAG_C] = asC;
          vars_nxt.sreg[FLAG_H] = asH;
        end
        OP_INCR, OP_DECR: begin
          vars_nxt.dst = asRes;
          vars_nxt.sreg[FLAG_Z] = asRes == BYTE_ZERO;
          vars_nxt.sreg[FLAG_N] = asRes[7];
          vars_nxt.sreg[FLAG_V] = asV;
        end
        OP_WORD_INC, OP_WORD_DEC: begin
          cyc = CYC_TWO;
          vars_nxt.word = wordRes;
          vars_nxt.sreg[FLAG_Z] = wordRes == 16'h0000;
          vars_nxt.sreg[FLAG_C] = wordC;
          vars_nxt.sreg[FLAG_N] = wordRes[15];
          vars_nxt.sreg[FLAG_V] = wordV;
          vars_nxt.sreg[FLAG_S] = wordRes[15] ^ wordV;
        end
        OP_AND, OP_AND_IMM, OP_OR, OP_OR_IMM, OP_XOR, OP_SET_MASK, OP_CLEAR_MASK,
        OP_ZERO_MINUS_CHECK, OP_CLEAR_REG: begin
          // carry and half carry are left alone on purpose
          vars_nxt.dst = logRes;
          vars_nxt.sreg[FLAG_Z] = logRes == BYTE_ZERO;
          vars_nxt.sreg[FLAG_N] = logRes[7];
          vars_nxt.sreg[FLAG_V] = 1'b0;
        end
        OP_ONES_COMP: begin
          vars_nxt.dst = BYTE_ONES - vars_r.dst;
          vars_nxt.sreg[FLAG_Z] = vars_r.dst == BYTE_ONES;
          vars_nxt.sreg[FLAG_N] = !vars_r.dst[7];
          vars_nxt.sreg[FLAG_V] = 1'b0;
          vars_nxt.sreg[FLAG_C] = 1'b1;
        end
        OP_SET_REG: vars_nxt.dst = BYTE_ONES;
        OP_PROD_U, OP_PROD_S, OP_PROD_SU, OP_FRAC_U, OP_FRAC_S, OP_FRAC_SU: begin
          cyc = CYC_TWO;
          vars_nxt.prod = mulProd;
          vars_nxt.sreg[FLAG_Z] = mulProd == 16'h0000;
          vars_nxt.sreg[FLAG_C] = mulC;
        end
        OP_REL_GOTO: begin
          cyc = CYC_TWO;
          vars_nxt.pc = pcInc + vars_r.imm;
        end
        OP_IND_GOTO: begin
          cyc = CYC_TWO;
          vars_nxt.pc = vars_r.zptr;
        end
        OP_ABS_GOTO: begin
          cyc = CYC_THREE;
          vars_nxt.pc = vars_r.imm;
        end
        OP_REL_ENTRY, OP_IND_ENTRY, OP_ABS_ENTRY: begin
          // the stack wraps when full; software keeps nesting below the depth
          vars_nxt.stack[vars_r.sp] = (opIn == OP_ABS_ENTRY) ? vars_r.pc + PC_STEP_TWO : pcInc;
          vars_nxt.sp = SP_W'(vars_r.sp + 1'b1);
          if (opIn == OP_REL_ENTRY) begin
            cyc = CYC_THREE;
            vars_nxt.pc = pcInc + vars_r.imm;
          end else if (opIn == OP_IND_ENTRY) begin
            cyc = CYC_THREE;
            vars_nxt.pc = vars_r.zptr;
          end else begin
            cyc = CYC_FOUR;
            vars_nxt.pc = vars_r.imm;
          end
        end
        OP_SUB_EXIT, OP_HANDLER_EXIT: begin
          cyc = CYC_FOUR;
          vars_nxt.sp = SP_W'(vars_r.sp - 1'b1);
          vars_nxt.pc = vars_r.stack[SP_W'(vars_r.sp - 1'b1)];
          if (opIn == OP_HANDLER_EXIT) begin
            vars_nxt.sreg[FLAG_I] = 1'b1;
          end
        end
        OP_EQUAL_SKIP: begin
          if (vars_r.dst == vars_r.src) begin
            vars_nxt.skipped = 1'b1;
            cyc = longNext ? CYC_THREE : CYC_TWO;
            vars_nxt.pc = vars_r.pc + (longNext ? PC_STEP_THREE : PC_STEP_TWO);
          end
        end
        default: ;
      endcase
      vars_nxt.lastCyc = cyc;
      vars_nxt.cnt = cyc - CYC_ONE;
      vars_nxt.state = (cyc == CYC_ONE) ? ST_IDLE : ST_RUN;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      vars_r <= '{state: ST_IDLE, op: OP_ADD, pc: PC_RESET, sreg: SREG_RESET, default: '0};
    end else begin
      vars_r <= vars_nxt;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  sequence cmdSeq(op_type o);
    avWrite && !avWaitrequest && (avAddress == REG_CMD) && (avWritedata[CMD_OP_MSB:CMD_OP_LSB] == o);
  endsequence

  sequence runFor2;
    busy ##1 !busy;
  endsequence

  a_adc_sum: assert property (cmdSeq(OP_ADD_CARRY) |=>
    vars_r.dst == 8'($past(vars_r.dst) + $past(vars_r.src) + {7'h00, $past(vars_r.sreg[FLAG_C])}))
    else $error("add with carry result wrong");
  a_word_inc_time: assert property (cmdSeq(OP_WORD_INC) |=> runFor2 and
    (vars_r.word == 16'($past(vars_r.word) + {10'h000, $past(vars_r.imm[5:0])})))
    else $error("word increase wrong or not two cycles");
  a_difference_immediate_carry: assert property (cmdSeq(OP_DIFF_IMM) |=>
    (vars_r.sreg[FLAG_C] == ($past(vars_r.dst) < $past(vars_r.imm[7:0]))) && !busy)
    else $error("immediate difference carry wrong");
  a_sbc_value: assert property (cmdSeq(OP_DIFF_BORROW) |=>
    vars_r.dst == 8'($past(vars_r.dst) - $past(vars_r.src) - {7'h00, $past(vars_r.sreg[FLAG_C])}))
    else $error("borrow difference wrong");
  a_masked_and_immediate_keep_c: assert property (cmdSeq(OP_AND_IMM) |=>
    $stable(vars_r.sreg[FLAG_C]) && $stable(vars_r.sreg[FLAG_H]) && !vars_r.sreg[FLAG_V])
    else $error("and immediate touched carry flags");
  a_ones_comp: assert property (cmdSeq(OP_ONES_COMP) |=>
    (vars_r.dst == ~$past(vars_r.dst)) && vars_r.sreg[FLAG_C])
    else $error("ones complement wrong");
  a_mul_product: assert property (cmdSeq(OP_PROD_U) |=> runFor2 and
    (vars_r.prod == 16'({8'h00, $past(vars_r.dst)} * {8'h00, $past(vars_r.src)})))
    else $error("unsigned product wrong");
  a_indirect_goto_target: assert property (cmdSeq(OP_IND_GOTO) |=>
    (vars_r.pc == $past(vars_r.zptr)) ##1 !busy)
    else $error("indirect goto wrong");
  a_indirect_subroutine_entry_time: assert property (cmdSeq(OP_IND_ENTRY) |=> busy [*2] ##1 !busy)
    else $error("indirect entry not three cycles");
  a_skip_equal: assert property (cmdSeq(OP_EQUAL_SKIP) ##0 (vars_r.dst == vars_r.src) |=>
    vars_r.skipped && (vars_r.pc - $past(vars_r.pc) >= PC_STEP_TWO))
    else $error("equal compare did not skip");
  a_interrupt_handler_exit_sets_i: assert property (cmdSeq(OP_HANDLER_EXIT) |=> vars_r.sreg[FLAG_I] ##3 !busy)
    else $error("handler exit did not set I");

endmodule : alu_branch_exec

// ### verilog/alu_exec_pkg.sv
package alu_exec_pkg;

  // ----------------------------------------------------------------
  // register map (word addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_CMD = 4'h0;
  localparam logic [ADDR_W-1:0] REG_DST = 4'h1;
  localparam logic [ADDR_W-1:0] REG_SRC = 4'h2;
  localparam logic [ADDR_W-1:0] REG_IMM = 4'h3;
  localparam logic [ADDR_W-1:0] REG_WORD = 4'h4;
  localparam logic [ADDR_W-1:0] REG_ZPTR = 4'h5;
  localparam logic [ADDR_W-1:0] REG_PC = 4'h6;
  localparam logic [ADDR_W-1:0] REG_SREG = 4'h7;
  localparam logic [ADDR_W-1:0] REG_PROD = 4'h8;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h9;

  // ----------------------------------------------------------------
  // field layouts
  // ----------------------------------------------------------------
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_OP_MSB = 5;
  localparam int CMD_LONG_BIT = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_SKIP_BIT = 1;
  localparam int STAT_CYC_LSB = 4;
  localparam int STAT_SP_LSB = 8;
  localparam int WORD_K_W = 6;
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_I = 7;

  // ----------------------------------------------------------------
  // reset values, constants, cycle counts
  // ----------------------------------------------------------------
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] SREG_RESET = 8'h00;
  localparam logic [7:0] BYTE_ONES = 8'hff;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [15:0] PC_STEP_ONE = 16'h0001;
  localparam logic [15:0] PC_STEP_TWO = 16'h0002;
  localparam logic [15:0] PC_STEP_THREE = 16'h0003;
  localparam int CYC_W = 3;
  localparam logic [CYC_W-1:0] CYC_ONE = 3'h1;
  localparam logic [CYC_W-1:0] CYC_TWO = 3'h2;
  localparam logic [CYC_W-1:0] CYC_THREE = 3'h3;
  localparam logic [CYC_W-1:0] CYC_FOUR = 3'h4;

  typedef enum logic [5:0] {
    OP_ADD, OP_ADD_CARRY, OP_WORD_INC, OP_SUB, OP_DIFF_IMM, OP_DIFF_BORROW, OP_DIFF_IMM_BORROW,
    OP_WORD_DEC, OP_AND, OP_AND_IMM, OP_OR, OP_OR_IMM, OP_XOR, OP_ONES_COMP, OP_TWOS_COMP,
    OP_SET_MASK, OP_CLEAR_MASK, OP_INCR, OP_DECR, OP_ZERO_MINUS_CHECK, OP_CLEAR_REG, OP_SET_REG,
    OP_PROD_U, OP_PROD_S, OP_PROD_SU, OP_FRAC_U, OP_FRAC_S, OP_FRAC_SU,
    OP_REL_GOTO, OP_IND_GOTO, OP_ABS_GOTO, OP_REL_ENTRY, OP_IND_ENTRY, OP_ABS_ENTRY,
    OP_SUB_EXIT, OP_HANDLER_EXIT, OP_EQUAL_SKIP, OP_COMPARE
  } op_type;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN = 1'b1
  } state_type;

endpackage : alu_exec_pkg

// ### verilog/mul_unit.sv
`timescale 1ns/10ps
module mul_unit (
  // operands
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic signA,
  input wire logic signB,
  input wire logic frac,
  // product
  output logic [15:0] product,
  output logic carry
);
  logic signed [8:0] ax;
  logic signed [8:0] bx;
  logic signed [17:0] full;

  assign ax = {signA & a[7], a};
  assign bx = {signB & b[7], b};
  assign full = ax * bx;
  // carry is taken from the product before the fractional shift
  assign carry = full[15];
  assign product = frac ? {full[14:0], 1'b0} : full[15:0];
endmodule : mul_unit
